//--- ccu_pkg.sv
// Package for the capture/compare unit: control layouts, mode codes, carriers.
// Assumes a single 250 MHz system clock and an external 16-bit timer.
package ccu_pkg;

  // ****************************************************************
  // Control register layout
  // ****************************************************************
  localparam int CCU_CTL_W = 8;
  localparam int CCU_CTL_EN_BIT = 7;
  localparam int CCU_CTL_OUT_BIT = 5;
  localparam int CCU_MODE_HI = 3;
  localparam int CCU_MODE_LO = 0;
  localparam int CCU_SRC_W = 2;
  localparam int CCU_VAL_W = 16;
  localparam int CCU_BYTE_W = 8;
  localparam int CCU_PSC_W = 4;

  localparam logic [CCU_CTL_W-1:0] CCU_CTL_RST = 8'h00;
  localparam logic [CCU_VAL_W-1:0] CCU_VAL_RST = 16'h0000;
  localparam logic [CCU_PSC_W-1:0] CCU_PSC_RST = 4'h0;
  localparam logic [CCU_PSC_W-1:0] CCU_PSC_LAST4 = 4'h3;
  localparam logic [CCU_PSC_W-1:0] CCU_PSC_LAST16 = 4'hf;

  // ****************************************************************
  // Mode codes
  // ****************************************************************
  localparam logic [3:0] CCU_M_OFF = 4'h0;
  localparam logic [3:0] CCU_M_TGL_CLR = 4'h1;
  localparam logic [3:0] CCU_M_TGL = 4'h2;
  localparam logic [3:0] CCU_M_CAP_ANY = 4'h3;
  localparam logic [3:0] CCU_M_CAP_FALL = 4'h4;
  localparam logic [3:0] CCU_M_CAP_RISE = 4'h5;
  localparam logic [3:0] CCU_M_CAP_R4 = 4'h6;
  localparam logic [3:0] CCU_M_CAP_R16 = 4'h7;
  localparam logic [3:0] CCU_M_SET = 4'h8;
  localparam logic [3:0] CCU_M_CLR = 4'h9;
  localparam logic [3:0] CCU_M_PULSE = 4'ha;
  localparam logic [3:0] CCU_M_PULSE_CLR = 4'hb;

  // Capture source select codes.
  localparam logic [CCU_SRC_W-1:0] CCU_SRC_PIN = 2'h0;
  localparam logic [CCU_SRC_W-1:0] CCU_SRC_ALT0 = 2'h1;
  localparam logic [CCU_SRC_W-1:0] CCU_SRC_ALT1 = 2'h2;
  localparam logic [CCU_SRC_W-1:0] CCU_SRC_ALT2 = 2'h3;

  // Register write strobes and data travel together.
  typedef struct packed {
    logic ctl_we;
    logic lo_we;
    logic hi_we;
    logic [CCU_CTL_W-1:0] wdata;
  } ccu_wr_t;

  // Open-drain capable pin drive.
  typedef struct packed {
    logic o;
    logic oe;
  } ccu_pin_t;

endpackage

//--- ccu_value_reg.sv
// Capture/compare value storage as two byte-wide registers.
// Assumes writes and captures are synchronous to ref_clk.
`timescale 1ns/1ps
module ccu_value_reg
  import ccu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Updates
  input wire logic cap,
  input wire logic [CCU_VAL_W-1:0] cap_val,
  input wire logic lo_we,
  input wire logic hi_we,
  input wire logic [CCU_BYTE_W-1:0] wbyte,
  // Contents
  output logic [CCU_VAL_W-1:0] val_q
);

  // Capture overwrites both bytes; byte writes change only their own half.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      val_q <= CCU_VAL_RST;
    else if (cap)
      val_q <= cap_val;
    else
    begin
      if (lo_we)
        val_q[CCU_BYTE_W-1:0] <= wbyte;
      if (hi_we)
        val_q[CCU_VAL_W-1:CCU_BYTE_W] <= wbyte;
    end
  end

endmodule

//--- ccu_unit.sv
// Capture/compare unit top: mode decode, edge capture, compare and output.
// Assumes timer count, pin and alternate sources are synchronous to ref_clk.
`timescale 1ns/1ps
module ccu_unit
  import ccu_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register writes and configuration
  input wire ccu_wr_t wr,
  input wire logic [CCU_SRC_W-1:0] capture_input_select_reg,
  input wire logic open_drain_en,
  input wire logic flag_clear,
  // Timer and sleep
  input wire logic [CCU_VAL_W-1:0] capture_timer_count,
  input wire logic timer_ext_clk,
  input wire logic sleep,
  // Capture sources
  input wire logic unit_pin_in,
  input wire logic pin_direction_bit,
  input wire logic [2:0] alt_src,
  // Outputs
  output logic [CCU_CTL_W-1:0] unit_control_reg,
  output logic [CCU_BYTE_W-1:0] value_low_byte,
  output logic [CCU_BYTE_W-1:0] value_high_byte,
  output logic unit_event_flag,
  output logic timer_reset,
  output logic timer_hold,
  output logic unit_out,
  output ccu_pin_t unit_pin
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_n;

  // Two-stage release of the asynchronous reset.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // ****************************************************************
  // Control register and mode decode
  // ****************************************************************
  typedef enum logic [2:0] {
    CCU_ST_IDLE = 3'b001,
    CCU_ST_CAP = 3'b010,
    CCU_ST_CMP = 3'b100
  } ccu_state_t;

  logic [CCU_CTL_W-1:0] ctl_q;
  logic [3:0] mode;
  logic en;
  ccu_state_t state;

  function automatic logic is_capture(input logic [3:0] m);
    is_capture = (m >= CCU_M_CAP_ANY) && (m <= CCU_M_CAP_R16);
  endfunction

  function automatic logic is_compare(input logic [3:0] m);
    is_compare = (m == CCU_M_TGL_CLR) || (m == CCU_M_TGL) ||
                 ((m >= CCU_M_SET) && (m <= CCU_M_PULSE_CLR));
  endfunction

  // Control register written whole by software.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctl_q <= CCU_CTL_RST;
    else if (wr.ctl_we)
      ctl_q <= wr.wdata;
  end

  assign mode = ctl_q[CCU_MODE_HI:CCU_MODE_LO];
  assign en = ctl_q[CCU_CTL_EN_BIT];
  assign unit_control_reg = ctl_q;

  // Operating group derived from enable and mode.
  always_comb
  begin
    if (en && is_capture(mode))
      state = CCU_ST_CAP;
    else if (en && is_compare(mode))
      state = CCU_ST_CMP;
    else
      state = CCU_ST_IDLE;
  end

  // ****************************************************************
  // Capture path
  // ****************************************************************
  logic src;
  logic src_q;
  logic rise;
  logic fall;
  logic [CCU_PSC_W-1:0] psc_q;
  logic cap_evt;
  logic psc_hit;

  // The pin level is read back whatever drives it, so a port write to an
  // output pin is seen as an edge just like an external one.
  always_comb
  begin
    unique case (capture_input_select_reg)
      CCU_SRC_PIN: src = unit_pin_in;
      CCU_SRC_ALT0: src = alt_src[0];
      CCU_SRC_ALT1: src = alt_src[1];
      CCU_SRC_ALT2: src = alt_src[2];
    endcase
  end

  // Previous source level for edge detection; it runs in every mode, so a
  // mode change sees no stale edge, though a source change may see a false one.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      src_q <= 1'b0;
    else
      src_q <= src;
  end

  // Sleep with the instruction clock stops capture; external clock keeps it.
  assign rise = src && !src_q && !(sleep && !timer_ext_clk);
  assign fall = !src && src_q && !(sleep && !timer_ext_clk);

  always_comb
  begin
    unique case (mode)
      CCU_M_CAP_R4: psc_hit = (psc_q[1:0] == CCU_PSC_LAST4[1:0]);
      CCU_M_CAP_R16: psc_hit = (psc_q == CCU_PSC_LAST16);
      default: psc_hit = 1'b1;
    endcase
  end

  // Event selection by mode.
  always_comb
  begin
    cap_evt = 1'b0;
    if (state == CCU_ST_CAP)
    begin
      unique case (mode)
        CCU_M_CAP_FALL: cap_evt = fall;
        CCU_M_CAP_RISE: cap_evt = rise;
        CCU_M_CAP_ANY: cap_evt = rise || fall;
        default: cap_evt = rise && psc_hit;
      endcase
    end
  end

  // Rising-edge prescaler; not cleared on a change between capture modes.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      psc_q <= CCU_PSC_RST;
    else if (state != CCU_ST_CAP)
      psc_q <= CCU_PSC_RST;
    else if (rise)
      psc_q <= psc_q + 4'h1;
  end

  // ****************************************************************
  // Compare path
  // ****************************************************************
  logic [CCU_VAL_W-1:0] val_q;
  logic eq;
  logic eq_q;
  logic match;
  logic out_q;
  logic pulse_q;

  assign eq = (state == CCU_ST_CMP) && (val_q == capture_timer_count);
  assign match = eq && !eq_q;

  // Equality history for entry detection.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      eq_q <= 1'b0;
    else
      eq_q <= eq;
  end

  // Compare output latch; zero control write forces it low.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      out_q <= 1'b0;
    else if (wr.ctl_we && wr.wdata == CCU_CTL_RST)
      out_q <= 1'b0;
    else if (match)
    begin
      unique case (mode)
        CCU_M_TGL_CLR, CCU_M_TGL: out_q <= !out_q;
        CCU_M_SET: out_q <= 1'b1;
        CCU_M_CLR: out_q <= 1'b0;
        default: out_q <= out_q;
      endcase
    end
  end

  // One-cycle pulse for the pulse modes.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pulse_q <= 1'b0;
    else
      pulse_q <= match && (mode == CCU_M_PULSE || mode == CCU_M_PULSE_CLR);
  end

  // Timer reset request on match in the clearing modes.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      timer_reset <= 1'b0;
    else
      timer_reset <= match && (mode == CCU_M_TGL_CLR ||
                               mode == CCU_M_PULSE_CLR);
  end

  // Instruction-clocked timer halts in sleep and resumes its count.
  assign timer_hold = sleep && !timer_ext_clk;

  // ****************************************************************
  // Value register and flag
  // ****************************************************************
  ccu_value_reg u_val (
    .clk(ref_clk),
    .rst_n(rst_n),
    .cap(cap_evt),
    .cap_val(capture_timer_count),
    .lo_we(wr.lo_we),
    .hi_we(wr.hi_we),
    .wbyte(wr.wdata),
    .val_q(val_q)
  );

  assign value_low_byte = val_q[CCU_BYTE_W-1:0];
  assign value_high_byte = val_q[CCU_VAL_W-1:CCU_BYTE_W];

  // Sticky flag; a new event wins over a same-cycle clear.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      unit_event_flag <= 1'b0;
    else if (cap_evt || match)
      unit_event_flag <= 1'b1;
    else if (flag_clear)
      unit_event_flag <= 1'b0;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Internal compare signal for other peripherals and the pin.
  assign unit_out = ctl_q[CCU_CTL_OUT_BIT] ? pulse_q : out_q;

  // Open-drain drives only low; push-pull drives both levels.
  always_comb
  begin
    unit_pin.o = open_drain_en ? 1'b0 : unit_out;
    unit_pin.oe = (state == CCU_ST_CMP) && !pin_direction_bit &&
                  (!open_drain_en || !unit_out);
  end

endmodule

//--- ccu_unit_sva.sv
// Checker for the capture/compare unit, watching its top ports only.
// Assumes one clock domain with rstn as its reset.
`timescale 1ns/1ps
module ccu_unit_sva
  import ccu_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Watched inputs
  input wire ccu_wr_t wr,
  input wire logic flag_clear,
  input wire logic sleep,
  input wire logic timer_ext_clk,
  input wire logic open_drain_en,
  // Watched outputs
  input wire logic [CCU_CTL_W-1:0] unit_control_reg,
  input wire logic [CCU_BYTE_W-1:0] value_low_byte,
  input wire logic [CCU_BYTE_W-1:0] value_high_byte,
  input wire logic unit_event_flag,
  input wire logic timer_reset,
  input wire logic timer_hold,
  input wire logic unit_out,
  input wire ccu_pin_t unit_pin
);
  // All properties run on ref_clk and are off while rstn is low.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  a_flag_sticky: assert property (
    unit_event_flag && !flag_clear |=> unit_event_flag)
    else $error("Event flag dropped without a clear.");
  a_flag_fall: assert property (
    $fell(unit_event_flag) |-> $past(flag_clear))
    else $error("Event flag fell with no clear request.");
  a_treset_pulse: assert property (
    timer_reset |=> !timer_reset)
    else $error("Timer reset lasted over one cycle.");
  a_treset_mode: assert property (
    timer_reset |-> unit_control_reg[3:0] inside {4'h1, 4'hb})
    else $error("Timer reset in a mode without timer clear.");
  a_hold_sleep: assert property (
    timer_hold == (sleep && !timer_ext_clk))
    else $error("Timer hold disagrees with sleep and clock source.");
  a_zero_ctl: assert property (
    wr.ctl_we && wr.wdata == 8'h00 |=> !unit_out)
    else $error("Output not low after zero control write.");
  a_value_cause: assert property (
    $changed({value_high_byte, value_low_byte}) |->
    $past(wr.lo_we) || $past(wr.hi_we) || ($past(unit_control_reg[7])
    && !$past(timer_hold)
    && $past(unit_control_reg[3:0]) inside {[4'h3:4'h7]}))
    else $error("Value changed with no write or capture mode.");
  a_pin_odrain: assert property (
    open_drain_en && unit_pin.oe |-> !unit_pin.o)
    else $error("Open drain pin driven high.");
endmodule

bind ccu_unit ccu_unit_sva u_sva (
  .ref_clk(ref_clk), .rstn(rstn), .wr(wr), .flag_clear(flag_clear),
  .sleep(sleep), .timer_ext_clk(timer_ext_clk),
  .open_drain_en(open_drain_en), .unit_control_reg(unit_control_reg),
  .value_low_byte(value_low_byte), .value_high_byte(value_high_byte),
  .unit_event_flag(unit_event_flag), .timer_reset(timer_reset),
  .timer_hold(timer_hold), .unit_out(unit_out), .unit_pin(unit_pin));

//--- ccu_tmr_model.sv
// Model of the far side: the 16-bit timer and the pin with its pull-up.
// Assumes the bench loads and steps the timer on the system clock.
`timescale 1ns/1ps
module ccu_tmr_model
  import ccu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Timer control
  input wire logic run,
  input wire logic ld,
  input wire logic [CCU_VAL_W-1:0] ld_val,
  input wire logic hold,
  input wire logic clr,
  // Pin wiring
  input wire ccu_pin_t pin,
  input wire logic dir,
  input wire logic drv,
  input wire logic od,
  output logic lvl,
  output logic [CCU_VAL_W-1:0] cnt
);
  // Timer runs synchronously; it stops while held in sleep.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= '0;
    else if (clr)
      cnt <= '0;
    else if (ld)
      cnt <= ld_val;
    else if (run && !hold)
      cnt <= cnt + 16'h0001;
  end
  // An undriven pin follows the bench, which also stands for the port
  // latch; a released open-drain pin is pulled high.
  assign lvl = pin.oe ? pin.o : ((dir || !od) ? drv : 1'b1);
endmodule

//--- ccu_unit_tb.sv
// Self-checking bench for the capture/compare unit.
// Assumes the timer model stands still unless loaded or stepped.
`timescale 1ns/1ps
module ccu_unit_tb
  import ccu_pkg::*;
  ;
  logic ref_clk, rstn, flag_clear, ext, slp, od, dir, drv, run, ld;
  logic flag, trst, hold, uout, lvl;
  logic [1:0] sel;
  logic [2:0] alt;
  logic [7:0] ctl, lo, hi;
  logic [15:0] ldv, cnt;
  logic [31:0] r;
  ccu_wr_t wr;
  ccu_pin_t pin;
  int n_fail, compares, nrst, pc;

  ccu_unit dut (.ref_clk(ref_clk), .rstn(rstn), .wr(wr),
    .capture_input_select_reg(sel), .open_drain_en(od),
    .flag_clear(flag_clear), .capture_timer_count(cnt),
    .timer_ext_clk(ext), .sleep(slp), .unit_pin_in(lvl),
    .pin_direction_bit(dir), .alt_src(alt), .unit_control_reg(ctl),
    .value_low_byte(lo), .value_high_byte(hi), .unit_event_flag(flag),
    .timer_reset(trst), .timer_hold(hold), .unit_out(uout),
    .unit_pin(pin));
  ccu_tmr_model tmr (.clk(ref_clk), .rst_n(rstn), .run(run), .ld(ld),
    .ld_val(ldv), .hold(hold), .clr(trst), .pin(pin), .dir(dir),
    .drv(drv), .od(od), .lvl(lvl), .cnt(cnt));

  // Free-running 250 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Counts timer clear pulses from the unit.
  always @(posedge ref_clk)
    if (trst === 1'b1)
      nrst++;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    compares++;
    if (e !== g)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wrr(input int k, input logic [7:0] d);
    wr.ctl_we = (k == 0);
    wr.lo_we = (k == 1);
    wr.hi_we = (k == 2);
    wr.wdata = d;
    cyc(1);
    wr = '0;
    cyc(1);
  endtask
  task automatic clr_flag;
    flag_clear = 1'b1;
    cyc(1);
    flag_clear = 1'b0;
    cyc(1);
  endtask

  // Edge captures for every capture mode and every source.
  task automatic cap_test;
    logic [3:0] md [8] = '{4'h5, 4'h4, 4'h3, 4'h6, 4'h7, 4'h5, 4'h5, 4'h5};
    logic [15:0] ev;
    logic ef, p, q;
    ev = 16'h0000;
    for (int c = 0; c < 8; c++)
    begin
      wrr(0, 8'h00);
      sel = (c < 5) ? 2'h0 : 2'(c - 4);
      r = lfsr(r);
      slp = (c < 3) & r[0];
      ext = r[1];
      dir = r[2] | (c > 4);
      wrr(0, {4'h8, md[c]});
      clr_flag;
      pc = 0;
      p = 1'b0;
      ef = 1'b0;
      for (int e = 0; e < 34; e++)
      begin
        r = lfsr(r);
        ldv = r[15:0];
        ld = 1'b1;
        cyc(1);
        ld = 1'b0;
        p = ~p;
        if (sel == 2'h0)
          drv = p;
        else
          alt[sel - 2'h1] = p;
        cyc(3);
        q = (md[c] == 4'h3) || (md[c] == 4'h5 && p) || (md[c] == 4'h4 && !p);
        if (md[c] > 4'h5 && p)
        begin
          pc++;
          q = pc == (md[c] == 4'h6 ? 4 : 16);
          if (q)
            pc = 0;
        end
        if (slp && !ext)
          q = 1'b0;
        if (q)
        begin
          ev = ldv;
          ef = 1'b1;
        end
        chk("value", ev, {hi, lo});
        chk("flag", 16'(ef), 16'(flag));
        if (ef)
          clr_flag;
        ef = 1'b0;
      end
    end
  endtask

  // One match per compare mode; equality is then held, or the timer is cleared in the clearing modes.
  task automatic cmp_test;
    logic [3:0] cm [6] = '{4'h1, 4'h2, 4'h8, 4'h9, 4'ha, 4'hb};
    logic [15:0] v;
    logic eo, ec, pm;
    int k;
    dir = 1'b0;
    sel = 2'h0;
    slp = 1'b0;
    for (int c = 0; c < 6; c++)
    begin
      r = lfsr(r);
      v = r[15:0];
      od = r[16];
      eo = cm[c] inside {4'h1, 4'h2, 4'h8};
      ec = cm[c] inside {4'h1, 4'hb};
      pm = cm[c] inside {4'ha, 4'hb};
      wrr(0, 8'h00);
      clr_flag;
      chk("out zero", 16'h0000, 16'(uout));
      wrr(1, v[7:0]);
      wrr(2, v[15:8]);
      chk("bytes", v, {hi, lo});
      ldv = v - 16'h0001;
      ld = 1'b1;
      cyc(1);
      ld = 1'b0;
      wrr(0, {2'h2, pm, 1'b0, cm[c]});
      chk("control", 16'({2'h2, pm, 1'b0, cm[c]}), 16'(ctl));
      k = nrst;
      run = 1'b1;
      cyc(1);
      run = 1'b0;
      cyc(1);
      chk("pulse", 16'(eo | pm), 16'(uout));
      cyc(3);
      chk("flag", 16'h0001, 16'(flag));
      chk("out", 16'(eo), 16'(uout));
      chk("pin", 16'(eo), 16'(lvl));
      chk("timer", ec ? 16'h0000 : v, cnt);
      chk("resets", 16'(ec), 16'(nrst - k));
      clr_flag;
      cyc(8);
      chk("rematch", 16'h0000, 16'(flag));
      chk("out held", 16'(eo), 16'(uout));
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence: reset, captures, compares.
  initial
  begin
    r = 32'h09e5dd1c;
    wr = '0;
    {sel, alt, od, flag_clear, ext, slp, drv, run, ld} = '0;
    dir = 1'b1;
    ldv = '0;
    {n_fail, compares, nrst} = '0;
    rstn = 1'b0;
    cyc(2);
    rstn = 1'b1;
    cyc(3);
    cap_test;
    $display("Capture test done.");
    cmp_test;
    $display("Compare test done.");
    results;
  end
  // Watchdog set far beyond the fewer than two thousand cycles the tests need.
  initial
  begin
    #200000;
    n_fail++;
    results;
  end
endmodule
